// *** bench/testbench.sv ***
// Purpose: self-checking bench for the interrupt controller
// Assumes: zero wait slave, four clocks per instruction
// Notes:   software clears flags before each return
`timescale 1ns/1ps
`include "tlic_regs.vh"
module testbench;
    reg         hclk, hresetn, hsel, hwrite, tmr0_overflow, ext_pin_zero, port_b_read, ret_req;
    reg  [31:0] haddr, hwdata;
    reg  [1:0]  htrans;
    reg  [3:0]  port_pins;
    reg  [7:0]  periph_event;
    wire [31:0] hrdata;
    wire        hready, hresp, push_return, vector_load, instr_tick, ret_pulse, order_err;
    wire [20:0] vector_addr, pc;
    wire [3:0]  depth;
    int         failures, n_compared;
    tlic_controller tlic_controller_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .tmr0_overflow(tmr0_overflow), .ext_pin_zero(ext_pin_zero),
        .port_b_upper_pins(port_pins), .port_b_read(port_b_read), .periph_event(periph_event),
        .return_from_irq_instr(ret_pulse), .push_return(push_return),
        .vector_load(vector_load), .vector_addr(vector_addr), .instr_tick(instr_tick));
    tlic_core_model tlic_core_model_i (.hclk(hclk), .hresetn(hresetn),
        .push_return(push_return), .vector_load(vector_load), .vector_addr(vector_addr),
        .instr_tick(instr_tick), .ret_req(ret_req), .return_from_irq_instr(ret_pulse),
        .pc_reg(pc), .depth_reg(depth), .order_err(order_err));
    // clock
    always #4 hclk = ~hclk;
    task automatic wrap_up;
        begin
            $display("compared %0d failures %0d", n_compared, failures);
            if (failures == 0 && n_compared > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task automatic chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("ERROR at %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task automatic xfer(input [7:0] a, input w, input [7:0] wd, output [31:0] rd);
        int n;
        begin
            n = 0;
            hsel <= 1'b1; haddr <= {24'h00_0000, a}; htrans <= 2'h2; hwrite <= w;
            @(posedge hclk);
            while (hready !== 1'b1 && n < 50) begin @(posedge hclk); n++; end
            hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h00_0000, wd};
            @(posedge hclk);
            while (hready !== 1'b1 && n < 50) begin @(posedge hclk); n++; end
            rd = hrdata;
            if (n >= 50) begin failures = failures + 1; wrap_up(); end
        end
    endtask
    task automatic wr(input [7:0] a, input [7:0] d);
        reg [31:0] r;
        begin xfer(a, 1'b1, d, r); end
    endtask
    task automatic rd_chk(input [7:0] a, input [7:0] e);
        reg [31:0] r;
        begin xfer(a, 1'b0, 8'h00, r); chk(r, {24'h00_0000, e}); end
    endtask
    // wait for a vector load and compare its address
    task automatic wait_vec(input [20:0] e);
        int n;
        begin
            n = 0;
            @(negedge hclk);
            while (vector_load !== 1'b1 && n < 60) begin @(negedge hclk); n++; end
            chk({10'h000, vector_load, vector_addr}, {10'h000, 1'b1, e});
            @(posedge hclk);
        end
    endtask
    task automatic no_vec(input int cycles);
        reg seen;
        begin
            seen = 1'b0;
            repeat (cycles) begin @(negedge hclk); seen = seen | (vector_load !== 1'b0); end
            chk({31'h0, seen}, 32'h0000_0000);
            @(posedge hclk);
        end
    endtask
    task automatic ret;
        int n;
        begin
            n = 0;
            ret_req <= 1'b1;
            @(posedge hclk); ret_req <= 1'b0;
            while (ret_pulse !== 1'b1 && n < 20) begin @(negedge hclk); n++; end
            chk({31'h0, ret_pulse}, 32'h0000_0001);
            repeat (2) @(posedge hclk);
        end
    endtask
    task automatic pulse_tmr;
        begin tmr0_overflow <= 1'b1; @(posedge hclk); tmr0_overflow <= 1'b0; @(posedge hclk); end
    endtask
    task automatic t_reset;
        reg [7:0] exp [0:7];
        begin
            exp = '{8'h00, 8'h00, 8'h45, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
            for (int i = 0; i < 8; i++) rd_chk(8'(i * 4), exp[i]);
        end
    endtask
    task automatic t_compat;
        begin
            wr(8'h08, 8'h41); pulse_tmr();
            rd_chk(8'h00, 8'h04);
            wr(8'h00, 8'hA4); wait_vec(`TLIC_VEC_HIGH);
            rd_chk(8'h00, 8'h24);
            wr(8'h00, 8'h20); ret();
            rd_chk(8'h00, 8'hA0);
            wr(8'h00, 8'h80); wr(8'h10, 8'h01);
            periph_event <= 8'h01; @(posedge hclk); periph_event <= 8'h00;
            rd_chk(8'h0C, 8'h01);
            no_vec(24);
            wr(8'h00, 8'hC0); wait_vec(`TLIC_VEC_HIGH);
            rd_chk(8'h00, 8'h40);
            wr(8'h0C, 8'h00); ret(); rd_chk(8'h00, 8'hC0);
            wr(8'h00, 8'h00); wr(8'h10, 8'h00);
        end
    endtask
    task automatic t_prio;
        begin
            wr(8'h04, 8'h80); wr(8'h00, 8'h60); pulse_tmr();
            wait_vec(`TLIC_VEC_LOW);
            rd_chk(8'h00, 8'h24); rd_chk(8'h18, 8'h02);
            wr(8'h00, 8'h90); ext_pin_zero <= 1'b1;
            wait_vec(`TLIC_VEC_HIGH);
            rd_chk(8'h00, 8'h12); rd_chk(8'h18, 8'h03);
            wr(8'h00, 8'h60); pulse_tmr(); no_vec(40);
            wr(8'h00, 8'h00); ret(); rd_chk(8'h00, 8'h80);
            rd_chk(8'h18, 8'h02); ret(); rd_chk(8'h00, 8'hC0);
            rd_chk(8'h18, 8'h00); chk({27'h0, order_err, depth}, 32'h0000_0000);
            wr(8'h00, 8'h00); wr(8'h04, 8'h00);
        end
    endtask
    task automatic t_pins;
        begin
            wr(8'h08, 8'h01); ext_pin_zero <= 1'b0; repeat (6) @(posedge hclk);
            rd_chk(8'h00, 8'h02); wr(8'h00, 8'h00);
            ext_pin_zero <= 1'b1; repeat (6) @(posedge hclk);
            rd_chk(8'h00, 8'h00);
            port_pins <= 4'h5; repeat (6) @(posedge hclk);
            rd_chk(8'h00, 8'h01); wr(8'h00, 8'h00); rd_chk(8'h00, 8'h01);
            port_b_read <= 1'b1; @(posedge hclk); port_b_read <= 1'b0;
            repeat (2) @(posedge hclk); wr(8'h00, 8'h00); rd_chk(8'h00, 8'h00);
        end
    endtask
    // main sequence
    initial begin
        {hclk, hresetn, hsel, hwrite, tmr0_overflow, ext_pin_zero, port_b_read, ret_req} = 8'h00;
        {haddr, hwdata, htrans, port_pins, periph_event} = 78'h0;
        failures = 0; n_compared = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset(); t_compat(); t_prio(); t_pins();
        wrap_up();
    end
    // watchdog
    initial begin #100000; failures = failures + 1; wrap_up(); end
endmodule // testbench

// *** bench/tlic_checker_asserts.sv ***
// Purpose: port checks on the interrupt controller
// Assumes: one clock, hresetn async low
// Notes:   bound to every tlic_controller
`timescale 1ns/1ps
`include "tlic_regs.vh"
module tlic_checker #(
    parameter CLK_PER_INSTR = 4
) (
    input wire        hclk,
    input wire        hresetn,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        push_return,
    input wire        vector_load,
    input wire [20:0] vector_addr,
    input wire        instr_tick
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    reg [3:0] since_push_reg;
    reg [3:0] tick_gap_reg;
    // edges since last push and since last tick, saturating
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_push_reg <= 4'hF;
            tick_gap_reg   <= 4'h0;
        end else begin
            since_push_reg <= push_return ? 4'h1 : since_push_reg + {3'h0, since_push_reg != 4'hF};
            tick_gap_reg   <= instr_tick ? 4'h1 : tick_gap_reg
                + {3'h0, tick_gap_reg != 4'h0 && tick_gap_reg != 4'hF}; // zero until first tick
        end
    end
    a_load_after_push: assert property (vector_load |-> since_push_reg == CLK_PER_INSTR)
        else $error("vector load not one instruction after push");
    a_push_one_cycle: assert property (push_return |=> !push_return)
        else $error("push pulse longer than one cycle");
    a_push_not_load: assert property (push_return |-> !vector_load)
        else $error("push and load together");
    a_vector_value: assert property (vector_load |-> vector_addr == `TLIC_VEC_HIGH
        || vector_addr == `TLIC_VEC_LOW) else $error("vector address illegal");
    a_vector_holds: assert property (!vector_load |-> $stable(vector_addr))
        else $error("vector address moved without load");
    a_push_on_tick: assert property (push_return |-> $past(instr_tick))
        else $error("push off instruction boundary");
    a_tick_period: assert property (instr_tick && tick_gap_reg != 4'h0
        |-> tick_gap_reg == CLK_PER_INSTR) else $error("instruction tick period wrong");
    a_okay_resp: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus response not okay");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    c_high: cover property (vector_load && vector_addr == `TLIC_VEC_HIGH);
    c_low: cover property (vector_load && vector_addr == `TLIC_VEC_LOW);
    c_push: cover property (push_return ##4 vector_load);
endmodule // tlic_checker

bind tlic_controller tlic_checker #(.CLK_PER_INSTR(CLK_PER_INSTR)) tlic_checker_i (
    .hclk(hclk), .hresetn(hresetn), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .push_return(push_return), .vector_load(vector_load), .vector_addr(vector_addr),
    .instr_tick(instr_tick));

// *** bench/tlic_core_model.sv ***
// Purpose: core sequencer model taking push and load pulses
// Assumes: return requested by the bench lands on the next instruction tick
// Notes:   flags a load that was not preceded by a push
`timescale 1ns/1ps
module tlic_core_model (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        push_return,
    input  wire        vector_load,
    input  wire [20:0] vector_addr,
    input  wire        instr_tick,
    input  wire        ret_req,
    output reg         return_from_irq_instr,
    output reg  [20:0] pc_reg,
    output reg  [3:0]  depth_reg,
    output reg         order_err
);
    reg ret_pend_reg;
    reg pushed_reg;
    // stack depth, pc and return issue on instruction boundaries
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            return_from_irq_instr <= 1'b0;
            pc_reg <= 21'h00_0000;
            depth_reg <= 4'h0;
            order_err <= 1'b0;
            ret_pend_reg <= 1'b0;
            pushed_reg <= 1'b0;
        end else begin
            return_from_irq_instr <= ret_pend_reg && instr_tick;
            ret_pend_reg <= ret_req || (ret_pend_reg && !instr_tick);
            if (push_return) begin
                depth_reg <= depth_reg + 4'h1;
                pushed_reg <= 1'b1;
            end else if (vector_load) begin
                order_err <= order_err || !pushed_reg;
                pushed_reg <= 1'b0;
                pc_reg <= vector_addr;
            end else if (return_from_irq_instr) begin
                depth_reg <= depth_reg - 4'h1;
            end
        end
    end
endmodule // tlic_core_model

// *** rtl/tlic_controller.v ***
// Purpose: two-level prioritised interrupt controller with AHB-Lite register slave
// Assumes: core takes push and load pulses; instruction rate is a divided enable
// Notes:   slave is zero wait state, response always OKAY
`timescale 1ns/1ps
`include "tlic_regs.vh"

// How it works
// R1 - high level vectors to 0008h, low level to 0018h.
// R2 - a pending high request nests above a running low routine.
// R3 - every source has a flag, an enable and a priority bit; here external pin zero has no priority bit and is always high.
// R4 - two-level scheme only while priority mode bit 7 of reset control is set.
// R5 - in priority mode bit 7 enables all high-priority sources.
// R6 - in priority mode bit 6 enables all low-priority sources.
// R7 - flag, enable and level enable all set vectors at once.
// R8 - priority mode clear by default; per-source priorities then ignored.
// R9 - compatibility mode: bit 6 gates peripherals, bit 7 gates everything.
// R10 - compatibility mode always vectors to 0008h.
// R11 - accepting clears the global enable in use.
// R12 - no low-priority service while a high routine runs.
// R13 - push return address first, then load the vector.
// R14 - software clears serviced flags before re-enabling.
// R15 - return instruction sets the enable cleared on entry again.
// R16 - pin and port-change latency is three to four instruction cycles.
// R17 - flags set regardless of any enable.
// R18 - software avoids memory-to-memory moves on these registers while enabled.
// R19 - bit 7 is all-unmasked enable, or high enable in priority mode.
// R20 - bit 6 enables low-priority peripherals in priority mode.
// R21 - bit 2 timer zero overflow flag, sticky; bit 5 its enable.
// R22 - bit 1 external pin zero flag, sticky; bit 4 its enable.
// R23 - bit 0 port change flag, bit 3 enable; mismatch keeps setting it.
// R24 - edge select: 1 rising, 0 falling on the external pin.
// R25 - simultaneous high and low requests: high first.
// R26 - external pins synchronised before edge detection.
module tlic_controller #(
    parameter CLK_PER_INSTR = `TLIC_CLK_PER_INSTR,
    parameter NUM_PERIPH    = 8
) (
    input  wire                    hclk,
    input  wire                    hresetn,
    input  wire                    hsel,
    input  wire [31:0]             haddr,
    input  wire [1:0]              htrans,
    input  wire                    hwrite,
    input  wire [2:0]              hsize,
    input  wire [31:0]             hwdata,
    input  wire                    hready,
    output reg  [31:0]             hrdata,
    output wire                    hreadyout,
    output wire                    hresp,
    input  wire                    tmr0_overflow,
    input  wire                    ext_pin_zero,
    input  wire [3:0]              port_b_upper_pins,
    input  wire                    port_b_read,
    input  wire [NUM_PERIPH-1:0]   periph_event,
    input  wire                    return_from_irq_instr,
    output reg                     push_return,
    output reg                     vector_load,
    output reg  [`TLIC_PC_W-1:0]   vector_addr,
    output wire                    instr_tick
);
    localparam ST_IDLE = 2'd0;
    localparam ST_PUSH = 2'd1;
    localparam ST_LOAD = 2'd2;
    localparam DIV_W   = 8;

    reg  [7:0]            main_ctrl_reg;
    reg  [7:0]            main_ctrl_next;
    reg                   prio_mode_reg;
    reg  [7:0]            ctrl_two_reg;
    reg  [NUM_PERIPH-1:0] pflag_reg;
    reg  [NUM_PERIPH-1:0] pflag_next;
    reg  [NUM_PERIPH-1:0] pen_reg;
    reg  [NUM_PERIPH-1:0] pprio_reg;
    reg                   high_active_reg;
    reg                   low_active_reg;
    reg  [1:0]            state_reg;
    reg                   sel_high_reg;
    reg  [3:0]            port_latch_reg;
    reg  [DIV_W-1:0]      div_reg;
    reg                   dp_write_reg;
    reg  [7:0]            dp_addr_reg;
    wire [3:0]            port_level;
    wire                  ext0_rise;
    wire                  ext0_fall;
    wire                  ext0_event;
    wire                  port_mismatch;
    wire                  addr_phase;
    wire                  hi_req;
    wire                  lo_req;
    wire                  compat_req;
    wire                  accept;
    wire                  accept_high;

    // bus handshake: never stalls, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_phase = hsel & htrans[1] & hready;

    // decode a byte offset to the register's read value
    function [7:0] rd_mux;
        input [7:0] ofs;
        begin
            case (ofs)
                `TLIC_OFS_MAIN_CTRL:      rd_mux = main_ctrl_reg;
                `TLIC_OFS_RESET_CTRL:     rd_mux = {prio_mode_reg, 7'b000_0000};
                `TLIC_OFS_CTRL_TWO:       rd_mux = ctrl_two_reg;
                `TLIC_OFS_PERIPH_FLAGS:   rd_mux = pflag_reg;
                `TLIC_OFS_PERIPH_ENABLES: rd_mux = pen_reg;
                `TLIC_OFS_PERIPH_PRIOS:   rd_mux = pprio_reg;
                `TLIC_OFS_STATUS:         rd_mux = {6'b00_0000, low_active_reg, high_active_reg};
                default:                  rd_mux = 8'h00;
            endcase
        end
    endfunction

    // data-phase write strobe for one offset; state passed in so @* sees it
    function wr_hit;
        input       wr;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            wr_hit = wr & (addr == ofs);
        end
    endfunction

    // instruction-cycle enable from a divider
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= {DIV_W{1'b0}};
        end else if (div_reg == CLK_PER_INSTR[DIV_W-1:0] - 8'd1) begin
            div_reg <= {DIV_W{1'b0}};
        end else begin
            div_reg <= div_reg + 8'd1;
        end
    end
    assign instr_tick = (div_reg == CLK_PER_INSTR[DIV_W-1:0] - 8'd1);

    // external pin and port pins synchronised, edges found
    tlic_sync_edge #(.WIDTH(1)) u_ext0_sync (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .pin_in    (ext_pin_zero),
        .level_out (),
        .rise_out  (ext0_rise),
        .fall_out  (ext0_fall)
    ); // R26
    tlic_sync_edge #(.WIDTH(4)) u_port_sync (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .pin_in    (port_b_upper_pins),
        .level_out (port_level),
        .rise_out  (),
        .fall_out  ()
    ); // R26

    // edge select chooses rising or falling
    assign ext0_event = ctrl_two_reg[`TLIC_C2_EXT0_EDGE] ? ext0_rise : ext0_fall; // R24

    // port latch taken on a port read; mismatch against it
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_latch_reg <= 4'h0;
        end else if (port_b_read) begin
            port_latch_reg <= port_level; // R23
        end
    end
    assign port_mismatch = (port_level != port_latch_reg); // R23

    // bus address phase captured for the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_reg <= 1'b0;
            dp_addr_reg  <= 8'h00;
            hrdata       <= 32'h0000_0000;
        end else begin
            dp_write_reg <= addr_phase & hwrite;
            dp_addr_reg  <= {haddr[7:2], 2'b00};
            if (addr_phase & ~hwrite) begin
                hrdata <= {24'h00_0000, rd_mux({haddr[7:2], 2'b00})};
            end
        end
    end

    // request qualification per level
    assign hi_req = prio_mode_reg & main_ctrl_reg[`TLIC_MC_GLOBAL_HIGH] & (
        (main_ctrl_reg[`TLIC_MC_TMR0_FLAG] & main_ctrl_reg[`TLIC_MC_TMR0_EN]
            & ctrl_two_reg[`TLIC_C2_TMR0_PRIO]) |
        (main_ctrl_reg[`TLIC_MC_EXT0_FLAG] & main_ctrl_reg[`TLIC_MC_EXT0_EN]) |
        (main_ctrl_reg[`TLIC_MC_PORT_FLAG] & main_ctrl_reg[`TLIC_MC_PORT_EN]
            & ctrl_two_reg[`TLIC_C2_PORT_PRIO]) |
        (|(pflag_reg & pen_reg & pprio_reg))); // R4 R5 R7 R19 R3
    assign lo_req = prio_mode_reg & main_ctrl_reg[`TLIC_MC_PERIPH_LOW] & ~high_active_reg & (
        (main_ctrl_reg[`TLIC_MC_TMR0_FLAG] & main_ctrl_reg[`TLIC_MC_TMR0_EN]
            & ~ctrl_two_reg[`TLIC_C2_TMR0_PRIO]) |
        (main_ctrl_reg[`TLIC_MC_PORT_FLAG] & main_ctrl_reg[`TLIC_MC_PORT_EN]
            & ~ctrl_two_reg[`TLIC_C2_PORT_PRIO]) |
        (|(pflag_reg & pen_reg & ~pprio_reg))); // R6 R12 R20 R7
    // priority bits play no part here
    assign compat_req = ~prio_mode_reg & main_ctrl_reg[`TLIC_MC_GLOBAL_HIGH] & (
        (main_ctrl_reg[`TLIC_MC_TMR0_FLAG] & main_ctrl_reg[`TLIC_MC_TMR0_EN]) |
        (main_ctrl_reg[`TLIC_MC_EXT0_FLAG] & main_ctrl_reg[`TLIC_MC_EXT0_EN]) |
        (main_ctrl_reg[`TLIC_MC_PORT_FLAG] & main_ctrl_reg[`TLIC_MC_PORT_EN]) |
        (main_ctrl_reg[`TLIC_MC_PERIPH_LOW] & (|(pflag_reg & pen_reg)))); // R8 R9 R19

    // accepted only at an instruction boundary, one entry at a time
    assign accept      = instr_tick & (state_reg == ST_IDLE) & (hi_req | lo_req | compat_req);
    assign accept_high = hi_req | compat_req; // R25 R2

    // main control: software write, hardware flag set, entry clear, return set
    always @* begin
        main_ctrl_next = main_ctrl_reg;
        if (wr_hit(dp_write_reg, dp_addr_reg, `TLIC_OFS_MAIN_CTRL)) begin
            main_ctrl_next = hwdata[7:0];
        end
        // flags set on event regardless of enables, set wins over clear
        if (tmr0_overflow) begin
            main_ctrl_next[`TLIC_MC_TMR0_FLAG] = 1'b1; // R21 R17
        end
        if (ext0_event) begin
            main_ctrl_next[`TLIC_MC_EXT0_FLAG] = 1'b1; // R22 R17
        end
        if (port_mismatch) begin
            main_ctrl_next[`TLIC_MC_PORT_FLAG] = 1'b1; // R23 R17
        end
        // return sets the enable cleared on entry
        if (return_from_irq_instr) begin
            if (!prio_mode_reg) begin
                main_ctrl_next[`TLIC_MC_GLOBAL_HIGH] = 1'b1; // R15
            end else if (high_active_reg) begin
                main_ctrl_next[`TLIC_MC_GLOBAL_HIGH] = 1'b1; // R15
            end else if (low_active_reg) begin
                main_ctrl_next[`TLIC_MC_PERIPH_LOW] = 1'b1; // R15
            end
        end
        // entry clears the enable in use
        if (accept) begin
            if (!prio_mode_reg || hi_req) begin
                main_ctrl_next[`TLIC_MC_GLOBAL_HIGH] = 1'b0; // R11
            end else begin
                main_ctrl_next[`TLIC_MC_PERIPH_LOW] = 1'b0; // R11
            end
        end
    end

    // peripheral flags: set wins over software clear
    always @* begin
        pflag_next = pflag_reg;
        if (wr_hit(dp_write_reg, dp_addr_reg, `TLIC_OFS_PERIPH_FLAGS)) begin
            pflag_next = hwdata[NUM_PERIPH-1:0];
        end
        pflag_next = pflag_next | periph_event; // R17
    end

    // register file
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_ctrl_reg <= `TLIC_RST_MAIN_CTRL;
            prio_mode_reg <= 1'b0; // R8
            ctrl_two_reg  <= `TLIC_RST_CTRL_TWO;
            pflag_reg     <= {NUM_PERIPH{1'b0}};
            pen_reg       <= {NUM_PERIPH{1'b0}};
            pprio_reg     <= {NUM_PERIPH{1'b1}};
        end else begin
            main_ctrl_reg <= main_ctrl_next;
            pflag_reg     <= pflag_next;
            if (wr_hit(dp_write_reg, dp_addr_reg, `TLIC_OFS_RESET_CTRL)) begin
                prio_mode_reg <= hwdata[`TLIC_RC_PRIO_MODE]; // R4
            end
            if (wr_hit(dp_write_reg, dp_addr_reg, `TLIC_OFS_CTRL_TWO)) begin
                ctrl_two_reg <= hwdata[7:0] & `TLIC_C2_MASK;
            end
            if (wr_hit(dp_write_reg, dp_addr_reg, `TLIC_OFS_PERIPH_ENABLES)) begin
                pen_reg <= hwdata[NUM_PERIPH-1:0];
            end
            if (wr_hit(dp_write_reg, dp_addr_reg, `TLIC_OFS_PERIPH_PRIOS)) begin
                pprio_reg <= hwdata[NUM_PERIPH-1:0];
            end
        end
    end

    // active level tracking for nesting and return
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_active_reg <= 1'b0;
            low_active_reg  <= 1'b0;
        end else begin
            // a return ends the active level; a same-cycle entry overrides it
            if (return_from_irq_instr) begin
                if (high_active_reg) begin
                    high_active_reg <= 1'b0;
                end else begin
                    low_active_reg <= 1'b0;
                end
            end
            if (accept) begin
                if (!prio_mode_reg || hi_req) begin
                    high_active_reg <= 1'b1; // R2
                end else begin
                    low_active_reg <= 1'b1;
                end
            end
        end
    end

    // entry sequence: accept, push at next tick, load at the tick after
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg    <= ST_IDLE;
            sel_high_reg <= 1'b0;
            push_return  <= 1'b0;
            vector_load  <= 1'b0;
            vector_addr  <= {`TLIC_PC_W{1'b0}};
        end else begin
            push_return <= 1'b0;
            vector_load <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        sel_high_reg <= accept_high; // R25
                        state_reg    <= ST_PUSH;
                    end
                end
                ST_PUSH: begin
                    if (instr_tick) begin
                        push_return <= 1'b1; // R13
                        state_reg   <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (instr_tick) begin
                        vector_load <= 1'b1; // R13 R16
                        vector_addr <= sel_high_reg ? `TLIC_VEC_HIGH : `TLIC_VEC_LOW; // R1 R10
                        state_reg   <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // tlic_controller

// *** rtl/tlic_regs.vh ***
// Purpose: register offsets, field positions, reset values and timing counts of the controller
// Assumes: byte addresses on a 32-bit AHB-Lite bus, one aligned word per register
// Notes:   included by its bare name; definitions only
`ifndef TLIC_REGS_VH
`define TLIC_REGS_VH

// register byte offsets
`define TLIC_OFS_MAIN_CTRL      8'h00
`define TLIC_OFS_RESET_CTRL     8'h04
`define TLIC_OFS_CTRL_TWO       8'h08
`define TLIC_OFS_PERIPH_FLAGS   8'h0C
`define TLIC_OFS_PERIPH_ENABLES 8'h10
`define TLIC_OFS_PERIPH_PRIOS   8'h14
`define TLIC_OFS_STATUS         8'h18

// main control fields
`define TLIC_MC_GLOBAL_HIGH     7
`define TLIC_MC_PERIPH_LOW      6
`define TLIC_MC_TMR0_EN         5
`define TLIC_MC_EXT0_EN         4
`define TLIC_MC_PORT_EN         3
`define TLIC_MC_TMR0_FLAG       2
`define TLIC_MC_EXT0_FLAG       1
`define TLIC_MC_PORT_FLAG       0

// reset control and second control register fields
`define TLIC_RC_PRIO_MODE       7
`define TLIC_C2_EXT0_EDGE       6
`define TLIC_C2_TMR0_PRIO       2
`define TLIC_C2_PORT_PRIO       0
`define TLIC_C2_MASK            8'h45

// status fields
`define TLIC_ST_HIGH_ACTIVE     0
`define TLIC_ST_LOW_ACTIVE      1

// reset values
`define TLIC_RST_MAIN_CTRL      8'h00
`define TLIC_RST_RESET_CTRL     8'h00
`define TLIC_RST_CTRL_TWO       8'h45
`define TLIC_RST_PERIPH_FLAGS   8'h00
`define TLIC_RST_PERIPH_ENABLES 8'h00
`define TLIC_RST_PERIPH_PRIOS   8'hFF

// vectors and program counter width
`define TLIC_PC_W               21
`define TLIC_VEC_HIGH           21'h00_0008
`define TLIC_VEC_LOW            21'h00_0018

// timing: clocks per instruction cycle
`define TLIC_CLK_PER_INSTR      4

`endif

// *** rtl/tlic_sync_edge.v ***
// Purpose: two-flop synchroniser with edge detection for external pins
// Assumes: pins are asynchronous to hclk
// Notes:   only the second stage and later are looked at
`timescale 1ns/1ps
module tlic_sync_edge #(
    parameter WIDTH = 1
) (
    input  wire             hclk,
    input  wire             hresetn,
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] level_out,
    output wire [WIDTH-1:0] rise_out,
    output wire [WIDTH-1:0] fall_out
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;
    reg [WIDTH-1:0] last_reg;

    // two stages, then a history stage for edges
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
            last_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // one pulse per qualifying edge
    assign level_out = sync_reg;
    assign rise_out  = sync_reg & ~last_reg;
    assign fall_out  = ~sync_reg & last_reg;
endmodule // tlic_sync_edge
